// >>> rtl/diag_flags_pkg.sv
// shared constants and types for the diagnostic status flag link
package diag_flags_pkg;
  localparam int FLAG_W = 16;
  // status word bit positions
  localparam int BIT_RESET_IND = 0;
  localparam int BIT_WATCHDOG = 1;
  localparam int BIT_REGULATOR = 2;
  localparam int BIT_CONFIG_CRC = 3;
  localparam int BIT_SELFTEST = 4;
  localparam int BIT_OVERFLOW = 5;
  localparam int BIT_XY_LIMIT = 6;
  localparam int BIT_MAGNITUDE = 7;
  localparam int BIT_VECTOR = 9;
  localparam int BIT_ROM = 10;
  localparam int BIT_XY_INVALID = 11;
  // activation bit positions
  localparam int EN_HARD_RESET = 0;
  localparam int EN_WATCHDOG = 1;
  localparam int EN_REGULATOR = 2;
  localparam int EN_CHECKSUM = 3;
  localparam int EN_SELFTEST = 4;
  localparam int EN_OVERFLOW = 5;
  localparam int EN_XY_LIMIT = 6;
  localparam int EN_MAGNITUDE = 7;
  localparam int EN_VECTOR = 9;
  // reset values and enable write mask
  localparam logic [15:0] FLAG_RESET = 16'h0001;
  localparam logic [15:0] ENABLE_RESET = 16'h02FE;
  localparam logic [15:0] ENABLE_MASK = 16'h02FF;
  // raw x/y limit in digits
  localparam logic signed [15:0] XY_LIMIT = 16'sd23230;
  // controller register offsets (plain port)
  localparam logic [1:0] ADDR_CMD = 2'h0;
  localparam logic [1:0] ADDR_ENABLE = 2'h1;
  localparam logic [1:0] ADDR_FLAGS = 2'h2;
  localparam logic [1:0] ADDR_SAFETY = 2'h3;
  // command register bits
  localparam int CMD_READ = 0;
  localparam int CMD_SNAP = 1;
  localparam int CMD_WRITE_EN = 2;
  // startup check lengths in cycles
  localparam int ROM_CHECK_CYCLES = 8;
  localparam int VECTOR_CHECK_CYCLES = 4;
  typedef enum logic [1:0] {
    HOST_IDLE = 2'b00,
    HOST_SELECT = 2'b01,
    HOST_WAIT = 2'b11,
    HOST_RELEASE = 2'b10
  } host_state_type;
endpackage

// >>> rtl/diag_host.sv
// host end: reads flags and writes activation bits on software order
`timescale 1ns/10ps
module diag_host
  import diag_flags_pkg::*;
(
  input wire logic sys_clk, // system clock
  input wire logic srst, // sync reset, active high
  diag_link_if.host link, // serial side
  input wire logic [1:0] addr, // register address
  input wire logic [15:0] wdata, // write data
  input wire logic wr, // write strobe
  input wire logic rd, // read strobe
  output logic [15:0] rdata // read data, cycle after rd
);
  typedef struct packed {
    host_state_type fsm;
    logic [2:0] cmd;
    logic [15:0] enables;
    logic [15:0] flags;
    logic safety;
    logic cs_n;
    logic rf;
    logic rs;
    logic snap;
    logic we;
    logic [15:0] rdata;
  } host_regs_type;
  host_regs_type state_reg;
  host_regs_type state_next;

  // one transfer per command: select, strobe, wait for data, release
  always_comb begin
    state_next = state_reg;
    state_next.rf = 1'b0;
    state_next.rs = 1'b0;
    state_next.snap = 1'b0;
    state_next.we = 1'b0;
    if (wr && addr == ADDR_ENABLE) begin
      state_next.enables = wdata;
    end
    case (state_reg.fsm)
      HOST_IDLE: begin
        if (wr && addr == ADDR_CMD) begin
          state_next.cmd = wdata[2:0];
          state_next.cs_n = 1'b0;
          state_next.fsm = HOST_SELECT;
        end
      end
      HOST_SELECT: begin
        state_next.rf = state_reg.cmd[CMD_READ] && !state_reg.cmd[CMD_SNAP];
        state_next.rs = state_reg.cmd[CMD_READ] && state_reg.cmd[CMD_SNAP];
        state_next.snap = state_reg.cmd[CMD_SNAP] && !state_reg.cmd[CMD_READ];
        state_next.we = state_reg.cmd[CMD_WRITE_EN];
        state_next.fsm = HOST_WAIT;
      end
      HOST_WAIT: begin
        state_next.fsm = HOST_RELEASE;
      end
      HOST_RELEASE: begin
        if (state_reg.cmd[CMD_READ]) begin
          state_next.flags = link.flags_rdata;
        end
        state_next.safety = link.safety_ok;
        state_next.cs_n = 1'b1;
        state_next.fsm = HOST_IDLE;
      end
      default: begin
        state_next.fsm = HOST_IDLE;
      end
    endcase
    case (addr)
      ADDR_CMD: state_next.rdata = {15'h0000, state_reg.fsm != HOST_IDLE};
      ADDR_ENABLE: state_next.rdata = state_reg.enables;
      ADDR_FLAGS: state_next.rdata = state_reg.flags;
      default: state_next.rdata = {15'h0000, state_reg.safety};
    endcase
    if (!rd) begin
      state_next.rdata = '0;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      state_reg <= '0;
      state_reg.fsm <= HOST_IDLE;
      state_reg.enables <= ENABLE_RESET;
      state_reg.cs_n <= 1'b1;
      state_reg.safety <= 1'b1;
    end else begin
      state_reg <= state_next;
    end
  end

  assign link.chip_select_n = state_reg.cs_n;
  assign link.read_flags = state_reg.rf;
  assign link.read_snapshot = state_reg.rs;
  assign link.snap_take = state_reg.snap;
  assign link.write_enable = state_reg.we;
  assign link.enable_wdata = state_reg.enables;
  assign rdata = state_reg.rdata;
endmodule // diag_host

// >>> rtl/diag_link_if.sv
// link between the sensor flag logic and its host controller
`timescale 1ns/10ps
interface diag_link_if;
  logic chip_select_n;
  logic read_flags;
  logic read_snapshot;
  logic snap_take;
  logic write_enable;
  logic [15:0] enable_wdata;
  logic [15:0] flags_rdata;
  logic safety_ok;
  modport sensor (
    input chip_select_n, read_flags, read_snapshot, snap_take, write_enable, enable_wdata,
    output flags_rdata, safety_ok
  );
  modport host (
    output chip_select_n, read_flags, read_snapshot, snap_take, write_enable, enable_wdata,
    input flags_rdata, safety_ok
  );
endinterface

// >>> rtl/diag_sensor.sv
// sensor end: diagnostic status flags and activation bits
`timescale 1ns/10ps
module diag_sensor
  import diag_flags_pkg::*;
(
  input wire logic sys_clk, // system clock
  input wire logic srst, // sync reset, active high
  diag_link_if.sensor link, // serial side
  input wire logic xy_input_invalid, // converter input check fails
  input wire logic rom_crc_fail, // rom checksum mismatch
  input wire logic vector_fail, // test vector out of limit
  input wire logic firmware_cycle_end, // firmware run finished
  input wire logic magnitude_bad, // compensated vector length out of range
  input wire logic signed [15:0] raw_x, // raw x value
  input wire logic signed [15:0] raw_y, // raw y value
  input wire logic overflow_event, // processor overflow
  input wire logic selftest_fail, // startup self-test failed
  input wire logic config_crc_fail, // config or fuse checksum mismatch
  input wire logic self_trim, // automatic calibration running
  input wire logic regulator_fault, // supply monitor fault
  input wire logic watchdog_overflow, // watchdog counter overflow
  output logic processor_run, // signal processor allowed to run
  output logic outputs_enable, // sensor outputs driven
  output logic pulls_enable, // pull resistors active
  output logic vector_check_busy, // test vector run in progress
  output logic hard_reset_pulse // internal reset request
);
  typedef struct packed {
    logic [15:0] enables;
    logic [15:0] snap;
    logic [15:0] rdata;
    logic safety;
    logic reset_ind;
    logic snap_reset_ind;
    logic xy_invalid;
    logic rom;
    logic [3:0] rom_cnt;
    logic vector;
    logic vector_failed;
    logic [2:0] vec_cnt;
    logic selftest;
    logic watchdog_stop;
    logic hard_reset_pending;
    logic hard_reset;
    logic cs_n_prev;
  } sensor_state_type;
  sensor_state_type state_reg;
  sensor_state_type state_next;
  logic [15:0] word;
  logic read_any;
  logic mag_flag, xy_flag, ov_flag, crc_flag, reg_flag, wd_flag;
  logic crc_active;
  logic chip_reset;
  logic xy_exceed;

  function automatic logic beyond(input logic signed [15:0] v);
    beyond = (v > XY_LIMIT) || (v < -XY_LIMIT);
  endfunction

  assign read_any = link.read_flags || link.read_snapshot;
  assign xy_exceed = beyond(raw_x) || beyond(raw_y);
  assign crc_active = state_reg.enables[EN_CHECKSUM] && !self_trim;
  // a hard reset request must clear the sticky flags too, or a stale error survives it
  assign chip_reset = srst || state_reg.hard_reset;

  // sticky flags, clear-on-read except the watchdog flag
  sticky_flag u_mag (.sys_clk(sys_clk), .srst(chip_reset), .reset_value(1'b0),
    .event_in(magnitude_bad && state_reg.enables[EN_MAGNITUDE]),
    .read_clear(read_any), .force_clear(1'b0), .flag(mag_flag));
  sticky_flag u_xy (.sys_clk(sys_clk), .srst(chip_reset), .reset_value(1'b0),
    .event_in(xy_exceed && state_reg.enables[EN_XY_LIMIT]),
    .read_clear(read_any), .force_clear(1'b0), .flag(xy_flag));
  sticky_flag u_ov (.sys_clk(sys_clk), .srst(chip_reset), .reset_value(1'b0),
    .event_in(overflow_event && state_reg.enables[EN_OVERFLOW]),
    .read_clear(read_any), .force_clear(1'b0), .flag(ov_flag));
  // held while the fault persists, cleared by a read after it is gone
  sticky_flag u_crc (.sys_clk(sys_clk), .srst(chip_reset), .reset_value(1'b0),
    .event_in(config_crc_fail && crc_active),
    .read_clear(read_any), .force_clear(1'b0), .flag(crc_flag));
  sticky_flag u_reg (.sys_clk(sys_clk), .srst(chip_reset), .reset_value(1'b0),
    .event_in(regulator_fault && state_reg.enables[EN_REGULATOR]),
    .read_clear(read_any), .force_clear(1'b0), .flag(reg_flag));
  // watchdog flag is only cleared by dropping its enable or by reset
  sticky_flag u_wd (.sys_clk(sys_clk), .srst(chip_reset), .reset_value(1'b0),
    .event_in(watchdog_overflow && state_reg.enables[EN_WATCHDOG]),
    .read_clear(1'b0), .force_clear(!state_reg.enables[EN_WATCHDOG]),
    .flag(wd_flag));

  // assemble the live status word
  always_comb begin
    word = '0;
    word[BIT_XY_INVALID] = state_reg.xy_invalid;
    word[BIT_ROM] = state_reg.rom;
    word[BIT_VECTOR] = state_reg.vector;
    word[BIT_MAGNITUDE] = mag_flag;
    word[BIT_XY_LIMIT] = xy_flag;
    word[BIT_OVERFLOW] = ov_flag;
    word[BIT_SELFTEST] = state_reg.selftest;
    word[BIT_CONFIG_CRC] = crc_flag;
    word[BIT_REGULATOR] = reg_flag;
    word[BIT_WATCHDOG] = wd_flag;
    word[BIT_RESET_IND] = state_reg.reset_ind;
  end

  // next-state logic for flags, checks, snapshot and reset request
  always_comb begin
    state_next = state_reg;
    state_next.cs_n_prev = link.chip_select_n;
    state_next.hard_reset = 1'b0;
    state_next.xy_invalid = xy_input_invalid;
    // rom check runs for a fixed time then shows only a failure
    if (state_reg.rom_cnt != 4'(ROM_CHECK_CYCLES)) begin
      state_next.rom_cnt = state_reg.rom_cnt + 4'h1;
      state_next.rom = 1'b1;
    end else begin
      state_next.rom = rom_crc_fail;
    end
    // vector check: startup run or host request
    if (state_reg.vec_cnt != 3'h0) begin
      state_next.vec_cnt = state_reg.vec_cnt - 3'h1;
      if (vector_fail) begin
        state_next.vector_failed = 1'b1;
      end
      if (state_reg.vec_cnt == 3'h1) begin
        state_next.enables[EN_VECTOR] = 1'b0;
      end
    end else if (state_reg.enables[EN_VECTOR]) begin
      state_next.vec_cnt = 3'(VECTOR_CHECK_CYCLES);
      state_next.vector_failed = 1'b0;
    end
    if (read_any) begin
      state_next.vector = 1'b0;
    end
    if (firmware_cycle_end && state_reg.vector_failed) begin
      state_next.vector = 1'b1;
    end
    // self-test failure shows only after a watchdog stop
    if (selftest_fail && state_reg.watchdog_stop) begin
      state_next.selftest = 1'b1;
    end
    if (wd_flag) begin
      state_next.watchdog_stop = 1'b1;
    end
    if (read_any) begin
      state_next.reset_ind = 1'b0;
      state_next.snap_reset_ind = 1'b0;
    end
    // safety bit stays low until a status read finds no flag set
    if (read_any) begin
      state_next.safety = 1'b1;
    end
    if ((word & ~FLAG_RESET) != '0) begin
      state_next.safety = 1'b0;
    end
    if (link.snap_take) begin
      state_next.snap = word;
    end
    if (link.write_enable) begin
      state_next.enables = link.enable_wdata & ENABLE_MASK;
      state_next.hard_reset_pending = link.enable_wdata[EN_HARD_RESET];
      state_next.enables[EN_HARD_RESET] = 1'b0;
    end
    // hard reset fires when chip select rises
    if (state_reg.hard_reset_pending && link.chip_select_n && !state_reg.cs_n_prev) begin
      state_next.hard_reset = 1'b1;
      state_next.hard_reset_pending = 1'b0;
    end
    if (link.read_snapshot) begin
      state_next.rdata = state_reg.snap;
      state_next.rdata[BIT_RESET_IND] = state_reg.snap_reset_ind;
    end else if (link.read_flags) begin
      state_next.rdata = word;
    end
  end

  // a hard reset request acts like a chip reset on the flags
  always_ff @(posedge sys_clk) begin
    if (srst || state_reg.hard_reset) begin
      state_reg <= '0;
      state_reg.enables <= ENABLE_RESET;
      state_reg.reset_ind <= 1'b1;
      state_reg.snap_reset_ind <= 1'b1;
      state_reg.safety <= 1'b1;
      state_reg.cs_n_prev <= 1'b1;
      state_reg.rom <= 1'b1;
    end else begin
      state_reg <= state_next;
    end
  end

  assign link.flags_rdata = state_reg.rdata;
  assign link.safety_ok = state_reg.safety;
  assign processor_run = !state_reg.rom && !state_reg.watchdog_stop;
  assign outputs_enable = !state_reg.watchdog_stop;
  assign pulls_enable = state_reg.watchdog_stop;
  assign vector_check_busy = state_reg.vec_cnt != 3'h0;
  assign hard_reset_pulse = state_reg.hard_reset;
endmodule // diag_sensor

// >>> rtl/sticky_flag.sv
// one clear-on-read sticky status flag
`timescale 1ns/10ps
module sticky_flag (
  input wire logic sys_clk, // system clock
  input wire logic srst, // sync reset
  input wire logic reset_value, // value shown while reset is held
  input wire logic event_in, // error condition this cycle
  input wire logic read_clear, // status read this cycle
  input wire logic force_clear, // clear that wins over an event
  output logic flag // flag value
);
  typedef struct packed {
    logic flag;
  } sticky_state_type;
  sticky_state_type state_reg;
  sticky_state_type state_next;
  // an event in the read cycle wins over the clear
  always_comb begin
    state_next = state_reg;
    if (force_clear) begin
      state_next.flag = 1'b0;
    end else if (event_in) begin
      state_next.flag = 1'b1;
    end else if (read_clear) begin
      state_next.flag = 1'b0;
    end
  end
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      state_reg <= '{flag: 1'b0};
      state_reg.flag <= 1'b0;
    end else begin
      state_reg <= state_next;
    end
  end
  assign flag = srst ? reset_value : state_reg.flag;
endmodule // sticky_flag

// >>> verif/diag_flags_checker.sv
// link checker for the diagnostic status flag link
`timescale 1ns/10ps
module diag_flags_checker
  import diag_flags_pkg::*;
(
  input wire logic sys_clk, // system clock
  input wire logic srst, // sync reset
  input wire logic chip_select_n, // frame select, low active
  input wire logic read_flags, // live word read
  input wire logic read_snapshot, // snapshot read
  input wire logic snap_take, // snapshot capture
  input wire logic write_enable, // activation bit load
  input wire logic [15:0] enable_wdata, // activation bits
  input wire logic [15:0] flags_rdata, // returned status word
  input wire logic safety_ok // safety bit
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (srst);
  logic rst_pend_reg;
  logic wd_off_reg;
  wire logic rd_any = read_flags | read_snapshot;
  wire logic strobe = rd_any | snap_take | write_enable;
  // reset indication is owed until a read; a hard reset owes it again
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      rst_pend_reg <= 1'b1;
      wd_off_reg <= 1'b0;
    end else if (write_enable) begin
      rst_pend_reg <= rst_pend_reg | enable_wdata[EN_HARD_RESET];
      wd_off_reg <= ~enable_wdata[EN_WATCHDOG] & ~enable_wdata[EN_HARD_RESET];
    end else if (rd_any) begin
      rst_pend_reg <= 1'b0;
    end
  end
  sequence s_open;
    $fell(chip_select_n) ##1 !chip_select_n;
  endsequence
  property p_frame_len;
    $fell(chip_select_n) |-> !chip_select_n [*3] ##1 chip_select_n;
  endproperty
  a_frame_len: assert property (p_frame_len) else $error("select low time wrong");
  property p_frame_strobe;
    s_open |-> $onehot({read_flags, read_snapshot, snap_take, write_enable});
  endproperty
  a_frame_strobe: assert property (p_frame_strobe) else $error("frame without one strobe");
  property p_strobe_slot;
    strobe |-> !$past(chip_select_n) && $past(chip_select_n, 2);
  endproperty
  a_strobe_slot: assert property (p_strobe_slot) else $error("strobe outside its slot");
  property p_strobe_once;
    strobe |=> !strobe;
  endproperty
  a_strobe_once: assert property (p_strobe_once) else $error("strobe longer than a cycle");
  property p_rdata_hold;
    !chip_select_n && !rd_any |=> $stable(flags_rdata);
  endproperty
  a_rdata_hold: assert property (p_rdata_hold) else $error("read word changed without read");
  property p_first_read;
    rd_any && rst_pend_reg |=> flags_rdata[BIT_RESET_IND];
  endproperty
  a_first_read: assert property (p_first_read) else $error("reset indication missing");
  property p_read_clears;
    read_flags && !rst_pend_reg |=> !flags_rdata[BIT_RESET_IND];
  endproperty
  a_read_clears: assert property (p_read_clears) else $error("reset indication not cleared");
  property p_wd_off;
    read_flags && wd_off_reg |=> !flags_rdata[BIT_WATCHDOG];
  endproperty
  a_wd_off: assert property (p_wd_off) else $error("watchdog flag kept while disabled");
endmodule // diag_flags_checker

// >>> verif/sensor_diagnostic_status_flags_tb.sv
// self-checking bench for both ends of the status flag link
`timescale 1ns/10ps
module sensor_diagnostic_status_flags_tb;
  import diag_flags_pkg::*;
  localparam logic [15:0] FLAG_MASK = 16'h0EFF;
  logic sys_clk, srst, wr, rd, rd_q;
  logic [1:0] addr;
  logic [15:0] wdata, rdata;
  logic xy_input_invalid, rom_crc_fail, vector_fail, firmware_cycle_end, magnitude_bad, overflow_event;
  logic selftest_fail, config_crc_fail, self_trim, regulator_fault, watchdog_overflow;
  logic processor_run, outputs_enable, pulls_enable, hard_reset_pulse, vector_check_busy;
  logic signed [15:0] raw_x, raw_y;
  logic [31:0] exp_q[$];
  logic [31:0] note;
  logic [31:0] seed = 32'd89;
  int n_compared = 0, mismatches = 0, cyc = 0, hr_n = 0;
  int pos [6] = '{BIT_MAGNITUDE, BIT_XY_LIMIT, BIT_XY_LIMIT, BIT_OVERFLOW, BIT_REGULATOR, BIT_CONFIG_CRC};
  diag_link_if link ();
  diag_sensor i_diag_sensor (.sys_clk, .srst, .link(link.sensor), .xy_input_invalid, .rom_crc_fail,
    .vector_fail, .firmware_cycle_end, .magnitude_bad, .raw_x, .raw_y, .overflow_event, .selftest_fail,
    .config_crc_fail, .self_trim, .regulator_fault, .watchdog_overflow, .processor_run, .outputs_enable,
    .pulls_enable, .vector_check_busy, .hard_reset_pulse);
  diag_host i_diag_host (.sys_clk, .srst, .link(link.host), .addr, .wdata, .wr, .rd, .rdata);
  diag_flags_checker i_diag_flags_checker (.sys_clk, .srst, .chip_select_n(link.chip_select_n),
    .read_flags(link.read_flags), .read_snapshot(link.read_snapshot), .snap_take(link.snap_take),
    .write_enable(link.write_enable), .enable_wdata(link.enable_wdata), .flags_rdata(link.flags_rdata),
    .safety_ok(link.safety_ok));
  task automatic check(input logic [15:0] seen, input logic [15:0] want);
    n_compared++;
    if (seen !== want) begin
      mismatches++;
      $display("FAIL t=%0t seen=%h want=%h", $time, seen, want);
    end
  endtask
  task automatic results();
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // xorshift source, kept inside the raw limit
  function automatic logic signed [15:0] rnd_xy();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return 16'(int'(seed % 32'd46461) - 23230);
  endfunction
  // one plain-port cycle: write, or read with its data in the next cycle
  task automatic bus(input logic [1:0] a, input logic [15:0] d, input logic w);
    @(posedge sys_clk);
    addr <= a;
    wdata <= d;
    wr <= w;
    rd <= ~w;
    @(posedge sys_clk);
    wr <= 1'b0;
    rd <= 1'b0;
  endtask
  task automatic rd_reg(input logic [1:0] a, input logic [15:0] m, input logic [15:0] v);
    exp_q.push_back({m, v & m});
    bus(a, 16'h0000, 1'b0);
  endtask
  // a command, a busy poll, then a wait that outlasts the frame
  task automatic op(input logic [15:0] c);
    bus(ADDR_CMD, c, 1'b1);
    rd_reg(ADDR_CMD, 16'h0001, 16'h0001);
    repeat (6) @(posedge sys_clk);
  endtask
  task automatic st(input logic [15:0] v);
    op(16'h0001);
    rd_reg(ADDR_FLAGS, FLAG_MASK, v);
  endtask
  task automatic en(input logic [15:0] v);
    bus(ADDR_ENABLE, v, 1'b1);
    op(16'h0004);
  endtask
  task automatic fw();
    @(posedge sys_clk) firmware_cycle_end <= 1'b1;
    @(posedge sys_clk) firmware_cycle_end <= 1'b0;
  endtask
  // raw x off value sits on the boundary, which must not trip; raw y off value is a random value inside the limit
  task automatic cause(input int i, input logic v);
    case (i)
      0: magnitude_bad <= v;
      1: raw_x <= v ? 16'sd23230 + 16'sd1 : 16'sd23230;
      2: raw_y <= v ? -16'sd23231 : rnd_xy();
      3: overflow_event <= v;
      4: regulator_fault <= v;
      5: config_crc_fail <= v;
      default: watchdog_overflow <= v;
    endcase
  endtask
  initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end
  // result watcher: each read result against the oldest note, plus the hang limit
  always @(posedge sys_clk) begin
    if (rd_q && exp_q.size() > 0) begin
      note = exp_q.pop_front();
      check(rdata & note[31:16], note[15:0]);
    end
    rd_q <= rd;
    if (hard_reset_pulse) begin
      hr_n++;
      check({15'h0000, link.chip_select_n}, 16'h0001);
    end
    cyc++;
    if (cyc > 5000) begin
      mismatches++;
      results();
    end
  end
  initial begin
    {srst, wr, rd, addr, wdata, raw_x, raw_y} = '0;
    {xy_input_invalid, rom_crc_fail, vector_fail, firmware_cycle_end, magnitude_bad, overflow_event} = '0;
    {selftest_fail, config_crc_fail, self_trim, regulator_fault, watchdog_overflow} = '0;
    srst = 1'b1;
    repeat (2) @(posedge sys_clk);
    srst <= 1'b0;
    // the startup vector run is under way one cycle after reset
    repeat (2) @(posedge sys_clk);
    check({15'h0000, vector_check_busy}, 16'h0001);
    repeat (18) @(posedge sys_clk);
    op(16'h0003);
    rd_reg(ADDR_FLAGS, FLAG_MASK, 16'h0001);
    st(16'h0000);
    rd_reg(ADDR_SAFETY, 16'h0001, 16'h0001);
    $display("test 1 done");
    for (int i = 0; i < 6; i++) begin
      cause(i, 1'b1);
      repeat (3) @(posedge sys_clk);
      cause(i, 1'b0);
      // a capture frame refreshes the host's safety copy without clearing anything
      op(16'h0002);
      rd_reg(ADDR_SAFETY, 16'h0001, 16'h0000);
      st(16'h0001 << pos[i]);
      st(16'h0000);
      op(16'h0003);
      rd_reg(ADDR_FLAGS, FLAG_MASK, 16'h0001 << pos[i]);
      rd_reg(ADDR_SAFETY, 16'h0001, 16'h0001);
    end
    $display("test 2 done");
    en(16'h021A);
    self_trim <= 1'b1;
    for (int i = 0; i < 6; i++) cause(i, 1'b1);
    repeat (4) @(posedge sys_clk);
    for (int i = 0; i < 6; i++) cause(i, 1'b0);
    st(16'h0000);
    self_trim <= 1'b0;
    en(ENABLE_RESET);
    repeat (8) @(posedge sys_clk);
    $display("test 3 done");
    xy_input_invalid <= 1'b1;
    st(16'h0800);
    st(16'h0800);
    xy_input_invalid <= 1'b0;
    st(16'h0000);
    $display("test 4 done");
    vector_fail <= 1'b1;
    en(ENABLE_RESET);
    repeat (8) @(posedge sys_clk);
    fw();
    st(16'h0200);
    fw();
    st(16'h0200);
    vector_fail <= 1'b0;
    en(ENABLE_RESET);
    repeat (8) @(posedge sys_clk);
    fw();
    op(16'h0001);
    fw();
    st(16'h0000);
    $display("test 5 done");
    selftest_fail <= 1'b1;
    cause(6, 1'b1);
    repeat (3) @(posedge sys_clk);
    cause(6, 1'b0);
    repeat (3) @(posedge sys_clk);
    check({13'h0000, processor_run, outputs_enable, pulls_enable}, 16'h0001);
    st(16'h0012);
    st(16'h0012);
    en(ENABLE_RESET & ~16'h0002);
    st(16'h0010);
    selftest_fail <= 1'b0;
    en(ENABLE_RESET | 16'h0001);
    repeat (20) @(posedge sys_clk);
    st(16'h0001);
    check({15'h0000, processor_run}, 16'h0001);
    check(16'(hr_n), 16'h0001);
    $display("test 6 done");
    results();
  end
endmodule // sensor_diagnostic_status_flags_tb
